// File: verilog/sss_pkg.sv
// What this block does
// - Arithmetic immediate right shift of source_b low word, sign filled, to dest
// - Arithmetic variable right shift, count from low five bits of source_a
// - Logical immediate right shift of source_b low word, zero filled
// - Logical variable right shift, count from low five bits of source_a
// - 64-bit mode: shift result bit 31 copied into upper 32 bits
// - Trapping subtract: source_a minus source_b into dest
// - Trapping subtract raises overflow when carries out of bits 30 and 31 differ
// - On overflow the destination register is not written
// - Wrapping subtract writes same difference, never raises overflow
// - 64-bit mode: difference bit 31 copied into upper 32 bits
// - Light sleep opcode decode starts transition to standby mode
// - After writeback and idle system bus, standby stops internal clocks only
// - Any interrupt or reset leaves standby for full speed
// - Deep sleep opcode decode starts transition to suspend mode
// - After writeback and idle bus, suspend also stops peripheral bus clock
// - Any interrupt or reset leaves suspend for full speed
package sss_pkg;
  localparam logic [5:0] OP_REG_FORMAT = 6'h00;
  localparam logic [5:0] OP_SYS_COPROC = 6'h10;
  localparam logic [5:0] FN_ARSH_IMM = 6'h03;
  localparam logic [5:0] FN_ARSH_VAR = 6'h07;
  localparam logic [5:0] FN_LRSH_IMM = 6'h02;
  localparam logic [5:0] FN_LRSH_VAR = 6'h06;
  localparam logic [5:0] FN_MINUS_TRAP = 6'h22;
  localparam logic [5:0] FN_MINUS_WRAP = 6'h23;
  localparam logic [5:0] FN_LIGHT_SLEEP = 6'h21;
  localparam logic [5:0] FN_DEEP_SLEEP = 6'h22;
  localparam int SYS_FLAG_POS = 25;
  localparam int WB_DELAY = 2;
  localparam logic [1:0] WB_CNT_RESET = 2'h0;
  typedef enum logic [1:0] {FULL_SPEED, WAIT_IDLE, STANDBY, SUSPEND} power_type;
endpackage

// File: verilog/shift_subtract_sleep_exec.sv
module shift_subtract_sleep_exec (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [63:0] SRC_A_VALUE,
  input wire logic [63:0] SRC_B_VALUE,
  input wire logic MODE_64,
  input wire logic CP0_USABLE,
  input wire logic SYS_BUS_IDLE,
  input wire logic INTERRUPT,
  input wire logic NMI_IN,
  input wire logic SOFT_RESET,
  output logic WB_EN,
  output logic [4:0] WB_DEST,
  output logic [63:0] WB_DATA,
  output logic OVERFLOW_EXC,
  output logic CP_UNUSABLE_EXC,
  output logic INSTR_ACCEPT,
  output logic CORE_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic EXTBUS_CLK_EN,
  output logic IN_STANDBY,
  output logic IN_SUSPEND
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] sext32(input logic [31:0] w);
    sext32 = {{32{w[31]}}, w};
  endfunction

  // Overflow seen as the sign carry of a 33-bit difference
  function automatic logic carry_ovf(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] d;
    d = {a[31], a} - {b[31], b};
    carry_ovf = d[32] ^ d[31];
  endfunction

  logic [5:0] opc;
  logic [5:0] fn;
  logic [4:0] shamt;
  logic [4:0] srca_idx;
  logic zero_srca;
  logic zero_shamt;
  logic reg_fmt;
  logic sys_fmt;
  logic [31:0] b_word;
  logic [31:0] diff;
  logic ovf;
  logic light_req;
  logic deep_req;
  logic wr_nxt;
  logic [31:0] res_nxt;
  logic busy;
  sss_pkg::power_type pwr_r;
  logic deep_r;
  logic [1:0] wb_cnt_r;
  logic in1_r, in2_r, nmi1_r, nmi2_r, sr1_r, sr2_r, id1_r, id2_r;

  assign opc = INSTR[31:26];
  assign fn = INSTR[5:0];
  assign shamt = INSTR[10:6];
  assign srca_idx = INSTR[25:21];
  assign zero_srca = (srca_idx == 5'h00);
  assign zero_shamt = (shamt == 5'h00);
  assign reg_fmt = INSTR_VALID && !busy && (opc == sss_pkg::OP_REG_FORMAT);
  assign sys_fmt = INSTR_VALID && !busy && (opc == sss_pkg::OP_SYS_COPROC) &&
                   INSTR[sss_pkg::SYS_FLAG_POS] && (INSTR[24:6] == 19'h00000);
  assign b_word = SRC_B_VALUE[31:0];
  assign diff = SRC_A_VALUE[31:0] - b_word;
  // Carry out of bit 30 differs from carry out of bit 31
  assign ovf = (SRC_A_VALUE[31] != b_word[31]) && (diff[31] != SRC_A_VALUE[31]);
  assign light_req = sys_fmt && (fn == sss_pkg::FN_LIGHT_SLEEP);
  assign deep_req = sys_fmt && (fn == sss_pkg::FN_DEEP_SLEEP);
  assign busy = (pwr_r != sss_pkg::FULL_SPEED);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    wr_nxt = 1'b0;
    res_nxt = 32'h00000000;
    if (reg_fmt) begin
      unique case (fn)
        sss_pkg::FN_ARSH_IMM: begin
          wr_nxt = zero_srca;
          res_nxt = 32'($signed(b_word) >>> shamt);
        end
        sss_pkg::FN_ARSH_VAR: begin
          wr_nxt = zero_shamt;
          res_nxt = 32'($signed(b_word) >>> SRC_A_VALUE[4:0]);
        end
        sss_pkg::FN_LRSH_IMM: begin
          wr_nxt = zero_srca;
          res_nxt = b_word >> shamt;
        end
        sss_pkg::FN_LRSH_VAR: begin
          wr_nxt = zero_shamt;
          res_nxt = b_word >> SRC_A_VALUE[4:0];
        end
        sss_pkg::FN_MINUS_TRAP: begin
          wr_nxt = zero_shamt && !ovf;
          res_nxt = diff;
        end
        sss_pkg::FN_MINUS_WRAP: begin
          wr_nxt = zero_shamt;
          res_nxt = diff;
        end
        default: begin
          wr_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      WB_EN <= 1'b0;
      WB_DEST <= 5'h00;
      WB_DATA <= 64'h0000000000000000;
    end else begin
      WB_EN <= wr_nxt;
      WB_DEST <= INSTR[15:11];
      // Upper word follows bit 31 in 64-bit mode and is zero in 32-bit mode; low word the same in both
      WB_DATA <= MODE_64 ? sext32(res_nxt) : {32'h00000000, res_nxt};
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      OVERFLOW_EXC <= 1'b0;
      CP_UNUSABLE_EXC <= 1'b0;
      INSTR_ACCEPT <= 1'b0;
    end else begin
      OVERFLOW_EXC <= reg_fmt && (fn == sss_pkg::FN_MINUS_TRAP) && zero_shamt && ovf;
      CP_UNUSABLE_EXC <= (light_req || deep_req) && !CP0_USABLE;
      INSTR_ACCEPT <= INSTR_VALID && !busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake and idle inputs come from other domains, so two flops each
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      in1_r <= 1'b0;
      in2_r <= 1'b0;
      nmi1_r <= 1'b0;
      nmi2_r <= 1'b0;
      sr1_r <= 1'b0;
      sr2_r <= 1'b0;
      id1_r <= 1'b0;
      id2_r <= 1'b0;
    end else begin
      in1_r <= INTERRUPT;
      in2_r <= in1_r;
      nmi1_r <= NMI_IN;
      nmi2_r <= nmi1_r;
      sr1_r <= SOFT_RESET;
      sr2_r <= sr1_r;
      id1_r <= SYS_BUS_IDLE;
      id2_r <= id1_r;
    end
  end

  logic wake;
  assign wake = in2_r || nmi2_r || sr2_r;

  // Cold reset is RESET itself; it forces full speed asynchronously
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pwr_r <= sss_pkg::FULL_SPEED;
      deep_r <= 1'b0;
      wb_cnt_r <= sss_pkg::WB_CNT_RESET;
    end else begin
      unique case (pwr_r)
        sss_pkg::FULL_SPEED: begin
          if ((light_req || deep_req) && CP0_USABLE) begin
            pwr_r <= sss_pkg::WAIT_IDLE;
            deep_r <= deep_req;
            wb_cnt_r <= sss_pkg::WB_CNT_RESET;
          end
        end
        sss_pkg::WAIT_IDLE: begin
          // Wait out writeback, then for an idle system bus
          if (wb_cnt_r != 2'(sss_pkg::WB_DELAY)) begin
            wb_cnt_r <= wb_cnt_r + 2'h1;
          end else if (id2_r) begin
            pwr_r <= deep_r ? sss_pkg::SUSPEND : sss_pkg::STANDBY;
          end
        end
        sss_pkg::STANDBY: begin
          if (wake) begin
            pwr_r <= sss_pkg::FULL_SPEED;
          end
        end
        sss_pkg::SUSPEND: begin
          if (wake) begin
            pwr_r <= sss_pkg::FULL_SPEED;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      CORE_CLK_EN <= 1'b1;
      PERIPH_CLK_EN <= 1'b1;
      EXTBUS_CLK_EN <= 1'b1;
      IN_STANDBY <= 1'b0;
      IN_SUSPEND <= 1'b0;
    end else begin
      CORE_CLK_EN <= (pwr_r != sss_pkg::STANDBY) && (pwr_r != sss_pkg::SUSPEND);
      PERIPH_CLK_EN <= (pwr_r != sss_pkg::SUSPEND);
      EXTBUS_CLK_EN <= 1'b1;
      IN_STANDBY <= (pwr_r == sss_pkg::STANDBY);
      IN_SUSPEND <= (pwr_r == sss_pkg::SUSPEND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_trap_no_write: assert property (@(posedge MCLK) disable iff (RESET)
    OVERFLOW_EXC |-> !WB_EN) else $error("overflow with writeback");

  a_trap_raise: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_MINUS_TRAP && zero_shamt && ovf |=> OVERFLOW_EXC)
    else $error("overflow missed");

  a_wrap_no_trap: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_MINUS_WRAP |=> !OVERFLOW_EXC)
    else $error("wrapping subtract trapped");

  a_upper_sext: assert property (@(posedge MCLK) disable iff (RESET)
    MODE_64 |=> WB_DATA[63:32] == {32{WB_DATA[31]}}) else $error("upper word wrong");

  a_lshift_result: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_LRSH_IMM && zero_srca |=>
    WB_EN && WB_DATA[31:0] == ($past(b_word) >> $past(shamt))) else $error("shift wrong");

  a_sub_result: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_MINUS_WRAP && zero_shamt |=>
    WB_DATA[31:0] == $past(diff)) else $error("difference wrong");

  a_cpu_exc: assert property (@(posedge MCLK) disable iff (RESET)
    (light_req || deep_req) && !CP0_USABLE |=> CP_UNUSABLE_EXC && pwr_r == sss_pkg::FULL_SPEED)
    else $error("sleep without permission");

  a_suspend_clk: assert property (@(posedge MCLK) disable iff (RESET)
    IN_SUSPEND |-> !PERIPH_CLK_EN && !CORE_CLK_EN && EXTBUS_CLK_EN)
    else $error("suspend clocks wrong");

  a_standby_clk: assert property (@(posedge MCLK) disable iff (RESET)
    IN_STANDBY |-> PERIPH_CLK_EN && !CORE_CLK_EN) else $error("standby clocks wrong");

  a_wake_exit: assert property (@(posedge MCLK) disable iff (RESET)
    (pwr_r == sss_pkg::STANDBY || pwr_r == sss_pkg::SUSPEND) && wake |=>
    pwr_r == sss_pkg::FULL_SPEED) else $error("no wake");

  ////////////////////////////////////////////////////////////////////////////
  a_arsh_imm_result: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_ARSH_IMM && zero_srca |=> WB_EN &&
    WB_DATA[31:0] == 32'($signed($past(b_word)) >>> $past(shamt))) else $error("sra wrong");

  a_arsh_sign_fill: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_ARSH_IMM && zero_srca && b_word[31] |=> WB_DATA[31])
    else $error("sign fill lost");

  a_arsh_var_result: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_ARSH_VAR && zero_shamt |=> WB_EN &&
    WB_DATA[31:0] == 32'($signed($past(b_word)) >>> $past(SRC_A_VALUE[4:0])))
    else $error("variable arithmetic shift wrong");

  a_lrsh_zero_top: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_LRSH_IMM && zero_srca && !zero_shamt |=> !WB_DATA[31])
    else $error("logical shift top not zero");

  a_lrsh_var_result: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_LRSH_VAR && zero_shamt |=> WB_EN &&
    WB_DATA[31:0] == ($past(b_word) >> $past(SRC_A_VALUE[4:0])))
    else $error("variable logical shift wrong");

  // Narrow mode keeps the upper word clear so stale bits never leak
  a_upper_narrow: assert property (@(posedge MCLK) disable iff (RESET)
    !MODE_64 |=> WB_DATA[63:32] == 32'h00000000) else $error("upper word not clear");

  a_trap_diff: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_MINUS_TRAP && zero_shamt && !ovf |=> WB_EN &&
    WB_DATA[31:0] == $past(SRC_A_VALUE[31:0]) - $past(SRC_B_VALUE[31:0]))
    else $error("trapping difference wrong");

  a_bad_field: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_MINUS_TRAP && !zero_shamt |=> !WB_EN && !OVERFLOW_EXC)
    else $error("bad field accepted");

  a_ovf_carries: assert property (@(posedge MCLK) disable iff (RESET)
    ovf == carry_ovf(SRC_A_VALUE[31:0], b_word)) else $error("overflow detect wrong");

  a_trap_suppress: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_MINUS_TRAP && zero_shamt && ovf |=> !WB_EN)
    else $error("overflowed result written");

  a_wrap_writes: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && fn == sss_pkg::FN_MINUS_WRAP && zero_shamt |=> WB_EN)
    else $error("wrapping subtract not written");

  a_sub_upper: assert property (@(posedge MCLK) disable iff (RESET)
    reg_fmt && MODE_64 && fn == sss_pkg::FN_MINUS_TRAP && zero_shamt |=>
    WB_DATA[63:32] == {32{WB_DATA[31]}}) else $error("difference upper wrong");

  a_light_enter: assert property (@(posedge MCLK) disable iff (RESET)
    light_req && CP0_USABLE |=> pwr_r == sss_pkg::WAIT_IDLE && !deep_r)
    else $error("light sleep not started");

  a_deep_enter: assert property (@(posedge MCLK) disable iff (RESET)
    deep_req && CP0_USABLE |=> pwr_r == sss_pkg::WAIT_IDLE && deep_r)
    else $error("deep sleep not started");

  // Core clock must outlast the writeback wait before any stop
  a_wait_writeback: assert property (@(posedge MCLK) disable iff (RESET)
    (light_req || deep_req) && CP0_USABLE |=> CORE_CLK_EN [*4])
    else $error("core stopped before writeback");

  a_idle_gate: assert property (@(posedge MCLK) disable iff (RESET)
    pwr_r == sss_pkg::WAIT_IDLE && !id2_r |=> pwr_r == sss_pkg::WAIT_IDLE)
    else $error("slept on busy bus");

  a_light_standby: assert property (@(posedge MCLK) disable iff (RESET)
    pwr_r == sss_pkg::WAIT_IDLE && !deep_r && wb_cnt_r == 2'(sss_pkg::WB_DELAY) && id2_r |=>
    pwr_r == sss_pkg::STANDBY) else $error("standby not entered");

  a_deep_suspend: assert property (@(posedge MCLK) disable iff (RESET)
    pwr_r == sss_pkg::WAIT_IDLE && deep_r && wb_cnt_r == 2'(sss_pkg::WB_DELAY) && id2_r |=>
    pwr_r == sss_pkg::SUSPEND) else $error("suspend not entered");

  a_busy_refuse: assert property (@(posedge MCLK) disable iff (RESET)
    INSTR_VALID && busy |=> !WB_EN && !INSTR_ACCEPT)
    else $error("instruction taken while asleep");

  a_standby_hold: assert property (@(posedge MCLK) disable iff (RESET)
    pwr_r == sss_pkg::STANDBY && !wake |=> pwr_r == sss_pkg::STANDBY)
    else $error("standby left without wake");

  a_clk_restore: assert property (@(posedge MCLK) disable iff (RESET)
    pwr_r == sss_pkg::FULL_SPEED |=> CORE_CLK_EN && PERIPH_CLK_EN)
    else $error("clocks off at full speed");

  a_suspend_wake: assert property (@(posedge MCLK) disable iff (RESET)
    pwr_r == sss_pkg::SUSPEND && wake |=> pwr_r == sss_pkg::FULL_SPEED)
    else $error("suspend not left");

  a_exc_no_write: assert property (@(posedge MCLK) disable iff (RESET)
    CP_UNUSABLE_EXC |-> !WB_EN) else $error("unusable with writeback");
endmodule // shift_subtract_sleep_exec

// File: tb/pipe_front_model.sv
module pipe_front_model (
  input wire logic mclk,
  input wire logic [31:0] instr,
  input wire logic wb_en,
  input wire logic [4:0] wb_dest,
  input wire logic [63:0] wb_data,
  input wire logic ld_en,
  input wire logic [4:0] ld_idx,
  input wire logic [31:0] ld_val,
  output logic [63:0] src_a,
  output logic [63:0] src_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] regs_r [32];
  // Loads are always stored sign extended, so 64-bit operands stay legal words
  always_ff @(posedge mclk) begin
    if (ld_en) begin
      regs_r[ld_idx] <= {{32{ld_val[31]}}, ld_val};
    end else if (wb_en) begin
      regs_r[wb_dest] <= wb_data;
    end
  end
  assign src_a = regs_r[instr[25:21]];
  assign src_b = regs_r[instr[20:16]];
endmodule // pipe_front_model

// File: tb/shift_subtract_sleep_exec_tb.sv
module shift_subtract_sleep_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic RESET = 1'b1, INSTR_VALID = 1'b0, MODE_64 = 1'b0, CP0_USABLE = 1'b1;
  logic SYS_BUS_IDLE = 1'b0, INTERRUPT = 1'b0, NMI_IN = 1'b0, SOFT_RESET = 1'b0;
  logic MCLK, WB_EN, OVERFLOW_EXC, CP_UNUSABLE_EXC, INSTR_ACCEPT, CORE_CLK_EN;
  logic PERIPH_CLK_EN, EXTBUS_CLK_EN, IN_STANDBY, IN_SUSPEND, ld_en = 1'b0;
  logic [31:0] INSTR = 32'h0, ld_val = 32'h0;
  logic [63:0] SRC_A_VALUE, SRC_B_VALUE, WB_DATA;
  logic [4:0] WB_DEST, ld_idx = 5'h00;
  logic [15:0] seed = 16'h9363;
  int fails = 0;
  int compares = 0;
  shift_subtract_sleep_exec dut (.MCLK(MCLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .SRC_A_VALUE(SRC_A_VALUE), .SRC_B_VALUE(SRC_B_VALUE), .MODE_64(MODE_64),
    .CP0_USABLE(CP0_USABLE), .SYS_BUS_IDLE(SYS_BUS_IDLE), .INTERRUPT(INTERRUPT),
    .NMI_IN(NMI_IN), .SOFT_RESET(SOFT_RESET), .WB_EN(WB_EN), .WB_DEST(WB_DEST),
    .WB_DATA(WB_DATA), .OVERFLOW_EXC(OVERFLOW_EXC), .CP_UNUSABLE_EXC(CP_UNUSABLE_EXC),
    .INSTR_ACCEPT(INSTR_ACCEPT), .CORE_CLK_EN(CORE_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .EXTBUS_CLK_EN(EXTBUS_CLK_EN), .IN_STANDBY(IN_STANDBY), .IN_SUSPEND(IN_SUSPEND));
  pipe_front_model partner (.mclk(MCLK), .instr(INSTR), .wb_en(WB_EN), .wb_dest(WB_DEST),
    .wb_data(WB_DATA), .ld_en(ld_en), .ld_idx(ld_idx), .ld_val(ld_val),
    .src_a(SRC_A_VALUE), .src_b(SRC_B_VALUE));
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [31:0] rf(input logic [4:0] a, b, s, input logic [5:0] f);
    return {sss_pkg::OP_REG_FORMAT, a, b, 5'h07, s, f};
  endfunction
  // Returns write, overflow, unusable and the written value
  function automatic logic [66:0] calc(input logic [31:0] i, input logic [63:0] a, b,
      input logic m64, ok);
    logic [31:0] r;
    logic wb;
    logic ov;
    logic cu;
    logic [5:0] f;
    logic [32:0] d;
    f = i[5:0];
    d = 33'h0;
    r = 32'h0;
    wb = 1'b0;
    ov = 1'b0;
    cu = 1'b0;
    if (i[31:26] == sss_pkg::OP_REG_FORMAT) begin
      if (f == sss_pkg::FN_ARSH_IMM || f == sss_pkg::FN_LRSH_IMM) begin
        wb = i[25:21] == 5'h00;
        r = b[31:0] >> i[10:6];
      end
      if (f == sss_pkg::FN_ARSH_VAR || f == sss_pkg::FN_LRSH_VAR) begin
        wb = i[10:6] == 5'h00;
        r = b[31:0] >> a[4:0];
      end
      if (f == sss_pkg::FN_ARSH_IMM) r = $signed(b[31:0]) >>> i[10:6];
      if (f == sss_pkg::FN_ARSH_VAR) r = $signed(b[31:0]) >>> a[4:0];
      if (f == sss_pkg::FN_MINUS_TRAP || f == sss_pkg::FN_MINUS_WRAP) begin
        r = a[31:0] - b[31:0];
        d = {a[31], a[31:0]} - {b[31], b[31:0]};
        ov = f == sss_pkg::FN_MINUS_TRAP && d[32] != d[31] && i[10:6] == 5'h00;
        wb = i[10:6] == 5'h00 && !ov;
      end
    end
    if (i[31:25] == {sss_pkg::OP_SYS_COPROC, 1'b1} && i[24:6] == 19'h0 &&
        (f == sss_pkg::FN_LIGHT_SLEEP || f == sss_pkg::FN_DEEP_SLEEP)) cu = !ok;
    return {wb, ov, cu, wb ? (m64 ? {{32{r[31]}}, r} : {32'h0, r}) : 64'h0};
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic load(input logic [4:0] i, input logic [31:0] v);
    @(posedge MCLK);
    ld_en <= 1'b1;
    ld_idx <= i;
    ld_val <= v;
    @(posedge MCLK);
    ld_en <= 1'b0;
  endtask
  task automatic run_op(input logic [31:0] ins, input logic acc);
    logic [66:0] e;
    @(posedge MCLK);
    INSTR <= ins;
    INSTR_VALID <= 1'b1;
    @(negedge MCLK);
    e = acc ? calc(ins, SRC_A_VALUE, SRC_B_VALUE, MODE_64, CP0_USABLE) : 67'h0;
    @(posedge MCLK);
    INSTR_VALID <= 1'b0;
    INSTR <= {rnd(), rnd()};
    @(negedge MCLK);
    chk("accept", acc, INSTR_ACCEPT);
    chk("wb_en", e[66], WB_EN);
    chk("overflow", e[65], OVERFLOW_EXC);
    chk("cp_unusable", e[64], CP_UNUSABLE_EXC);
    if (e[66]) chk("dest", ins[15:11], WB_DEST);
    if (e[66]) chk("data", e[63:0], WB_DATA);
  endtask
  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (CORE_CLK_EN !== lvl && n < 20) begin
      @(negedge MCLK);
      n++;
    end
    if (CORE_CLK_EN !== lvl) begin
      fails++;
      $display("Error core_clk_en expected %b seen %b", lvl, CORE_CLK_EN);
      give_verdict();
    end
  endtask
  task automatic sleep_op(input logic [5:0] fn, input int w);
    logic lt;
    lt = fn == sss_pkg::FN_LIGHT_SLEEP;
    run_op({sss_pkg::OP_SYS_COPROC, 1'b1, 19'h0, fn}, 1'b1);
    // Bus still busy: the core must still be running eight cycles on
    repeat (8) @(negedge MCLK);
    chk("core_busy", 1'b1, CORE_CLK_EN);
    @(posedge MCLK);
    SYS_BUS_IDLE <= 1'b1;
    wait_core(1'b0);
    chk("periph", lt, PERIPH_CLK_EN);
    chk("extbus", 1'b1, EXTBUS_CLK_EN);
    chk("mode", {lt, !lt}, {IN_STANDBY, IN_SUSPEND});
    run_op(rf(5'h03, 5'h02, 5'h00, sss_pkg::FN_MINUS_WRAP), 1'b0);
    @(posedge MCLK);
    INTERRUPT <= w == 0;
    NMI_IN <= w == 1;
    SOFT_RESET <= w == 2;
    wait_core(1'b1);
    chk("awake", 3'b100, {PERIPH_CLK_EN, IN_STANDBY, IN_SUSPEND});
    @(posedge MCLK);
    {INTERRUPT, NMI_IN, SOFT_RESET, SYS_BUS_IDLE} <= 4'h0;
    // Let the wake synchronisers drain before the next sleep
    repeat (4) @(posedge MCLK);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [5:0] fns [6];
    fns = '{sss_pkg::FN_ARSH_IMM, sss_pkg::FN_ARSH_VAR, sss_pkg::FN_LRSH_IMM,
      sss_pkg::FN_LRSH_VAR, sss_pkg::FN_MINUS_TRAP, sss_pkg::FN_MINUS_WRAP};
    repeat (6) @(posedge MCLK);
    RESET <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      @(posedge MCLK);
      MODE_64 <= m[0];
      load(5'h00, 32'h0);
      load(5'h01, 32'h80000000);
      load(5'h02, 32'h1);
      load(5'h03, 32'h7FFFFFFF);
      load(5'h04, 32'hFFFFFFFF);
      run_op(rf(5'h01, 5'h02, 5'h00, sss_pkg::FN_MINUS_TRAP), 1'b1);
      run_op(rf(5'h01, 5'h02, 5'h00, sss_pkg::FN_MINUS_WRAP), 1'b1);
      run_op(rf(5'h03, 5'h04, 5'h00, sss_pkg::FN_MINUS_TRAP), 1'b1);
      run_op(rf(5'h04, 5'h03, 5'h00, sss_pkg::FN_MINUS_TRAP), 1'b1);
      run_op(rf(5'h00, 5'h01, 5'h1F, sss_pkg::FN_ARSH_IMM), 1'b1);
      run_op(rf(5'h00, 5'h01, 5'h1F, sss_pkg::FN_LRSH_IMM), 1'b1);
      run_op(rf(5'h04, 5'h01, 5'h00, sss_pkg::FN_ARSH_VAR), 1'b1);
      run_op(rf(5'h00, 5'h01, 5'h00, sss_pkg::FN_LRSH_VAR), 1'b1);
      for (int i = 0; i < 40; i++) begin
        load(5'h05, {rnd(), rnd()});
        load(5'h06, {rnd(), rnd()});
        v = rnd();
        run_op(rf(v[0] ? 5'h05 : 5'h00, 5'h06, v[11] ? v[10:6] : 5'h00, fns[v[15:12] % 6]),
          1'b1);
      end
      $display("Test shift and subtract done");
    end
    for (int w = 0; w < 3; w++) begin
      sleep_op(sss_pkg::FN_LIGHT_SLEEP, w);
      sleep_op(sss_pkg::FN_DEEP_SLEEP, w);
    end
    $display("Test sleep and wake done");
    @(posedge MCLK);
    CP0_USABLE <= 1'b0;
    SYS_BUS_IDLE <= 1'b1;
    run_op({sss_pkg::OP_SYS_COPROC, 1'b1, 19'h0, sss_pkg::FN_DEEP_SLEEP}, 1'b1);
    repeat (8) @(negedge MCLK);
    chk("core_on", 1'b1, CORE_CLK_EN);
    $display("Test sleep without permission done");
    give_verdict();
  end
endmodule // shift_subtract_sleep_exec_tb
